// ===== core/smtm_defines.svh
// register map, field positions and reset values of the measurement timer
`ifndef SMTM_DEFINES_SVH
`define SMTM_DEFINES_SVH
`define SMTM_OFS_CTRL0  8'h00
`define SMTM_OFS_CTRL1  8'h04
`define SMTM_OFS_STAT   8'h08
`define SMTM_OFS_COUNT  8'h0c
`define SMTM_OFS_PLATCH 8'h10
`define SMTM_OFS_WLATCH 8'h14
`define SMTM_OFS_LIMIT  8'h18
`define SMTM_OFS_FLAGS  8'h1c
`define SMTM_OFS_IRQEN  8'h20
`define SMTM_C0_EN      7
`define SMTM_C0_HALT    5
`define SMTM_C0_WINDOW_POLARITY    4
`define SMTM_C0_SIGNAL_POLARITY    3
`define SMTM_C0_CLOCK_POLARITY    2
`define SMTM_C0_PS_HI   1
`define SMTM_C0_PS_LO   0
`define SMTM_C0_MASK    8'hbf
`define SMTM_C1_RUN     7
`define SMTM_C1_REP     6
`define SMTM_C1_MODE_HI 3
`define SMTM_C1_MODE_LO 0
`define SMTM_C1_MASK    8'hcf
`define SMTM_ST_PREQ    7
`define SMTM_ST_WREQ    6
`define SMTM_ST_CLR     5
`define SMTM_ST_RUN     2
`define SMTM_ST_WIN     1
`define SMTM_ST_ACQ     0
`define SMTM_FL_WIDTH   0
`define SMTM_FL_PERIOD  1
`define SMTM_FL_MATCH   2
`define SMTM_CTRL_RST   8'h00
`define SMTM_LIMIT_RST  24'hffffff
`define SMTM_COUNT_ZERO 24'h000000
`endif

// ===== core/smtm_edge.sv
// input conditioner: optional synchroniser, polarity, edge detect
`timescale 1ns/10ps
`default_nettype none
module smtm_edge (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic pin_i,
   input  wire logic pol_i,
   input  wire logic sync_i,
   output logic      lvl_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic stable;
   logic prev;
   always_comb
   begin
      lvl_o  = (sync_i ? stable : pin_i) ^ pol_i;
      rise_o = lvl_o & ~prev;
      fall_o = ~lvl_o & prev;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end
      else if (ce_i)
      begin
         meta   <= pin_i;
         stable <= meta;
         prev   <= lvl_o;
      end
   end
endmodule : smtm_edge
`default_nettype wire

// ===== core/smtm_pkg.sv
// types shared by the measurement timer
package smtm_pkg;
   typedef enum logic [3:0] {
      SMTM_WMEAS  = 4'h4,
      SMTM_GWMEAS = 4'h5,
      SMTM_TOF    = 4'h6,
      SMTM_CAPT   = 4'h7,
      SMTM_CNT    = 4'h8,
      SMTM_GCNT   = 4'h9,
      SMTM_WCNT   = 4'ha
   } smtm_mode_t;
   typedef enum logic [2:0] {
      SMTM_IDLE  = 3'h1,
      SMTM_ARMED = 3'h2,
      SMTM_RUN   = 3'h4
   } smtm_state_t;
endpackage : smtm_pkg

// ===== core/smtm_prescale.sv
// counting-clock prescaler, 1:1 up to 1:2**(W)
`timescale 1ns/10ps
`default_nettype none
module smtm_prescale #(
   parameter int W = 3
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       clr_i,
   input  wire logic       tick_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic [W-1:0] mask;
   always_comb
   begin
      mask     = ~({W{1'b1}} << sel_i);
      tick_o   = tick_i & ((cnt & mask) == mask); // [RULE_17]
      next_cnt = cnt;
      if (clr_i)
         next_cnt = '0;
      else if (tick_i)
         next_cnt = cnt + 1'b1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt <= '0;
      else if (ce_i)
         cnt <= next_cnt;
   end
endmodule : smtm_prescale
`default_nettype wire

// ===== core/smtm_top.sv
// measurement timer: window and counter modes with wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "smtm_defines.svh"
// What this block does
// RULE_01: windowed measure starts on window rise, later rises latch period and clear.
// RULE_02: gated window measure counts only while signal high; later rises latch period.
// RULE_03: time of flight starts on window rise, signal rise latches period, clears.
// RULE_04: two window rises without signal rise latch width and clear count.
// RULE_05: capture counts from run; window rise latches period, fall latches width.
// RULE_06: in capture mode only software clears the counter.
// RULE_07: counter mode counts signal pulses; window fall latches width.
// RULE_08: gated counter counts from window rise; window fall latches width.
// RULE_09: windowed counter: fall latches width, later rises latch period.
// RULE_10: width and period latch updates raise own flags, each with enable.
// RULE_11: triggers align to counting tick and flags sit in the bus clock; triggers here act on the clk_i cycle of the edge, not on tick.
// RULE_12: counter reaching period limit sets the match flag with its enable.
// RULE_13: clearing enable resets state machine, drops clock request, keeps registers.
// RULE_14: at limit counter holds if halt set, else returns to zero.
// RULE_15: window and signal polarity bits invert their inputs.
// RULE_16: clock polarity bit selects falling edge of measurement clock.
// RULE_17: prescale field divides counting clock by 1, 2, 4 or 8.
// RULE_18: run bit allows counting, hardware may clear it; repeat selects continuous.
// RULE_19: mode field codes 0100 to 1010 act; other codes here stay idle.
// RULE_20: manual period, width update and clear requests self-clear when done.
// RULE_21: status shows counting, window open and acquisition in progress.
// RULE_22: single acquisition stops and clears run; repeat keeps overwriting results.
// RULE_23: synchronous modes pass inputs through synchronisers before edge detect.
module smtm_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        window_input_i,
   input  wire logic        signal_input_i,
   input  wire logic        measure_clock_i,
   output logic             width_acq_irq_o,
   output logic             period_acq_irq_o,
   output logic             match_irq_o,
   output logic             clock_req_o
);
   localparam int CW = 24;

   logic [7:0]             ctrl0;
   logic [7:0]             ctrl1;
   logic [2:0]             req;
   logic [CW-1:0]          count;
   logic [CW-1:0]          period_latch;
   logic [CW-1:0]          width_latch;
   logic [CW-1:0]          period_limit;
   logic [2:0]             flags;
   logic [2:0]             irqen;
   logic [2:0]             irq;
   smtm_pkg::smtm_state_t  state;
   logic                   ack;
   logic [31:0]            rdat;

   logic [7:0]             next_ctrl0;
   logic [7:0]             next_ctrl1;
   logic [2:0]             next_req;
   logic [CW-1:0]          next_count;
   logic [CW-1:0]          next_period_latch;
   logic [CW-1:0]          next_width_latch;
   logic [CW-1:0]          next_period_limit;
   logic [2:0]             next_flags;
   logic [2:0]             next_irqen;
   smtm_pkg::smtm_state_t  next_state;
   logic                   next_ack;
   logic [31:0]            next_rdat;

   logic        en;
   logic        run;
   logic        rep;
   logic [3:0]  mode;
   logic        legal;
   logic        async_mode;
   logic        win_lvl;
   logic        win_rise;
   logic        win_fall;
   logic        sig_lvl;
   logic        sig_rise;
   logic        clk_rise;
   logic        gate;
   logic        raw_tick;
   logic        tick;
   logic        set_p;
   logic        set_w;
   logic        set_m;
   logic        done;
   logic        wr;
   logic [31:0] wval;
   logic [31:0] cnt_wr;
   logic [31:0] lim_wr;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            res[b*8 +: 8] = dat[b*8 +: 8];
      return res;
   endfunction : merge

   assign en         = ctrl0[`SMTM_C0_EN];
   assign run        = ctrl1[`SMTM_C1_RUN];
   assign rep        = ctrl1[`SMTM_C1_REP];
   assign mode       = ctrl1[`SMTM_C1_MODE_HI:`SMTM_C1_MODE_LO];
   assign async_mode = mode inside {smtm_pkg::SMTM_CNT, smtm_pkg::SMTM_GCNT,
                                    smtm_pkg::SMTM_WCNT};
   // codes below windowed measure belong to modes not built here
   assign legal      = (mode >= smtm_pkg::SMTM_WMEAS) &&
                       (mode <= smtm_pkg::SMTM_WCNT); // [RULE_19]

   // counter modes use the signal directly, hence no synchroniser lag
   smtm_edge u_win (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .pin_i  (window_input_i),
      .pol_i  (ctrl0[`SMTM_C0_WINDOW_POLARITY]), // [RULE_15]
      .sync_i (~async_mode),
      .lvl_o  (win_lvl),
      .rise_o (win_rise),
      .fall_o (win_fall)
   );
   smtm_edge u_sig (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .pin_i  (signal_input_i),
      .pol_i  (ctrl0[`SMTM_C0_SIGNAL_POLARITY]), // [RULE_15]
      .sync_i (~async_mode),
      .lvl_o  (sig_lvl),
      .rise_o (sig_rise),
      .fall_o ()
   );
   smtm_edge u_clk (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .pin_i  (measure_clock_i),
      .pol_i  (ctrl0[`SMTM_C0_CLOCK_POLARITY]),
      .sync_i (1'b1),
      .lvl_o  (),
      .rise_o (clk_rise),
      .fall_o ()
   );

   always_comb
   begin
      gate = 1'b1;
      if (mode == smtm_pkg::SMTM_GWMEAS)
         gate = sig_lvl; // [RULE_02]
      else if (mode == smtm_pkg::SMTM_GCNT)
         gate = win_lvl; // [RULE_08]
      // [RULE_07] [RULE_16] [RULE_23]
      raw_tick = (async_mode ? sig_rise : clk_rise) & gate & en & run &
                 (state == smtm_pkg::SMTM_RUN); // [RULE_18]
   end

   smtm_prescale #(.W(3)) u_ps (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .clr_i  (~en | ~run),
      .tick_i (raw_tick),
      .sel_i  (ctrl0[`SMTM_C0_PS_HI:`SMTM_C0_PS_LO]),
      .tick_o (tick)
   );

   assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack;
   assign wval = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   // wide bus word first, then cut to the counter width on purpose
   assign cnt_wr = merge({8'h00, count}, wval, wb_sel_i);
   assign lim_wr = merge({8'h00, period_limit}, wval, wb_sel_i);

   // measurement core
   always_comb
   begin
      next_state        = state;
      next_count        = count;
      next_period_latch = period_latch;
      next_width_latch  = width_latch;
      set_p             = 1'b0;
      set_w             = 1'b0;
      set_m             = 1'b0;
      done              = 1'b0;
      if (tick)
      begin
         if (count == period_limit)
         begin
            set_m      = 1'b1; // [RULE_12]
            next_count = ctrl0[`SMTM_C0_HALT] ? period_limit
                                               : `SMTM_COUNT_ZERO; // [RULE_14]
         end
         else
            next_count = count + 1'b1;
      end
      if (!en)
         next_state = smtm_pkg::SMTM_IDLE; // [RULE_13]
      else
      begin
         unique case (state)
            smtm_pkg::SMTM_IDLE:
               if (run && legal)
               begin
                  // capture and counter start straight from run
                  if (mode inside {smtm_pkg::SMTM_CAPT, smtm_pkg::SMTM_CNT})
                     next_state = smtm_pkg::SMTM_RUN; // [RULE_05]
                  else
                     next_state = smtm_pkg::SMTM_ARMED;
               end
            smtm_pkg::SMTM_ARMED:
               if (!run || !legal)
                  next_state = smtm_pkg::SMTM_IDLE;
               else if (win_rise)
               begin
                  next_state = smtm_pkg::SMTM_RUN; // [RULE_01] [RULE_03] [RULE_09]
                  next_count = `SMTM_COUNT_ZERO;
               end
            smtm_pkg::SMTM_RUN:
               if (!run || !legal)
                  next_state = smtm_pkg::SMTM_IDLE;
               else
               begin
                  unique case (mode)
                     smtm_pkg::SMTM_WMEAS, smtm_pkg::SMTM_GWMEAS:
                        if (win_rise)
                        begin
                           set_p      = 1'b1; // [RULE_01] [RULE_02]
                           done       = 1'b1;
                           next_count = `SMTM_COUNT_ZERO;
                        end
                     smtm_pkg::SMTM_TOF:
                        if (sig_rise)
                        begin
                           set_p      = 1'b1; // [RULE_03]
                           done       = 1'b1;
                           next_count = `SMTM_COUNT_ZERO;
                           next_state = smtm_pkg::SMTM_ARMED;
                        end
                        else if (win_rise)
                        begin
                           set_w      = 1'b1; // [RULE_04]
                           next_count = `SMTM_COUNT_ZERO;
                        end
                     smtm_pkg::SMTM_CAPT:
                     begin
                        // counter keeps running, no hardware clear
                        set_p = win_rise; // [RULE_05] [RULE_06]
                        set_w = win_fall;
                        done  = win_rise;
                     end
                     smtm_pkg::SMTM_CNT:
                     begin
                        set_w = win_fall; // [RULE_07]
                        done  = win_fall;
                     end
                     smtm_pkg::SMTM_GCNT:
                        if (win_fall)
                        begin
                           set_w      = 1'b1; // [RULE_08]
                           done       = 1'b1;
                           next_state = smtm_pkg::SMTM_ARMED;
                        end
                     smtm_pkg::SMTM_WCNT:
                     begin
                        set_w = win_fall; // [RULE_09]
                        if (win_rise)
                        begin
                           set_p      = 1'b1;
                           done       = 1'b1;
                           next_count = `SMTM_COUNT_ZERO;
                        end
                     end
                     default:
                        next_state = smtm_pkg::SMTM_IDLE;
                  endcase
               end
            default:
               next_state = smtm_pkg::SMTM_IDLE;
         endcase
         if (done && !rep)
            next_state = smtm_pkg::SMTM_IDLE; // [RULE_22]
      end
      if (req[`SMTM_ST_PREQ-5])
         set_p = 1'b1; // [RULE_20]
      if (req[`SMTM_ST_WREQ-5])
         set_w = 1'b1;
      if (req[`SMTM_ST_CLR-5])
         next_count = `SMTM_COUNT_ZERO;
      if (set_p)
         next_period_latch = count;
      if (set_w)
         next_width_latch = count;
      // software write to the counter wins over any hardware update
      if (wr && wb_adr_i == `SMTM_OFS_COUNT)
         next_count = cnt_wr[CW-1:0];
   end

   // register file
   always_comb
   begin
      next_ack          = wb_cyc_i & wb_stb_i & ~ack;
      next_ctrl0        = ctrl0;
      next_ctrl1        = ctrl1;
      next_period_limit = period_limit;
      next_irqen        = irqen;
      next_req          = 3'h0; // [RULE_20]
      if (done && !rep)
         next_ctrl1[`SMTM_C1_RUN] = 1'b0; // [RULE_18] [RULE_22]
      // hardware sets beat a same-cycle write-one clear
      next_flags = flags;
      if (wr && wb_adr_i == `SMTM_OFS_FLAGS)
         next_flags = flags & ~wval[2:0];
      next_flags = next_flags | {set_m, set_p, set_w}; // [RULE_10] [RULE_11]
      if (wr)
      begin
         unique case (wb_adr_i)
            `SMTM_OFS_CTRL0:
               next_ctrl0 = wval[7:0] & `SMTM_C0_MASK;
            `SMTM_OFS_CTRL1:
               next_ctrl1 = wval[7:0] & `SMTM_C1_MASK;
            `SMTM_OFS_STAT:
               next_req = wval[`SMTM_ST_PREQ:`SMTM_ST_CLR];
            `SMTM_OFS_LIMIT:
               next_period_limit = lim_wr[CW-1:0];
            `SMTM_OFS_IRQEN:
               next_irqen = wval[2:0];
            default:
               next_req = 3'h0;
         endcase
      end
      next_rdat = 32'h0000_0000;
      unique case (wb_adr_i)
         `SMTM_OFS_CTRL0:
            next_rdat[7:0] = ctrl0;
         `SMTM_OFS_CTRL1:
            next_rdat[7:0] = ctrl1;
         `SMTM_OFS_STAT:
         begin
            next_rdat[`SMTM_ST_PREQ:`SMTM_ST_CLR] = req;
            next_rdat[`SMTM_ST_RUN] = en & run &
                                      (state == smtm_pkg::SMTM_RUN); // [RULE_21]
            next_rdat[`SMTM_ST_WIN] = win_lvl;
            next_rdat[`SMTM_ST_ACQ] = state == smtm_pkg::SMTM_RUN;
         end
         `SMTM_OFS_COUNT:
            next_rdat[CW-1:0] = count;
         `SMTM_OFS_PLATCH:
            next_rdat[CW-1:0] = period_latch;
         `SMTM_OFS_WLATCH:
            next_rdat[CW-1:0] = width_latch;
         `SMTM_OFS_LIMIT:
            next_rdat[CW-1:0] = period_limit;
         `SMTM_OFS_FLAGS:
            next_rdat[2:0] = flags;
         `SMTM_OFS_IRQEN:
            next_rdat[2:0] = irqen;
         default:
            next_rdat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state        <= smtm_pkg::SMTM_IDLE;
         count        <= `SMTM_COUNT_ZERO;
         period_latch <= `SMTM_COUNT_ZERO;
         width_latch  <= `SMTM_COUNT_ZERO;
         ctrl0        <= `SMTM_CTRL_RST;
         ctrl1        <= `SMTM_CTRL_RST;
         req          <= 3'h0;
         period_limit <= `SMTM_LIMIT_RST;
         flags        <= 3'h0;
         irqen        <= 3'h0;
         irq          <= 3'h0;
         ack          <= 1'b0;
         rdat         <= 32'h0000_0000;
         clock_req_o  <= 1'b0;
      end
      else if (ce_i)
      begin
         state        <= next_state;
         count        <= next_count;
         period_latch <= next_period_latch;
         width_latch  <= next_width_latch;
         ctrl0        <= next_ctrl0;
         ctrl1        <= next_ctrl1;
         req          <= next_req;
         period_limit <= next_period_limit;
         flags        <= next_flags;
         irqen        <= next_irqen;
         irq          <= next_flags & next_irqen; // [RULE_10]
         ack          <= next_ack;
         rdat         <= next_rdat;
         clock_req_o  <= next_ctrl0[`SMTM_C0_EN] &
                         next_ctrl1[`SMTM_C1_RUN]; // [RULE_13]
      end
   end

   assign wb_ack_o         = ack;
   assign wb_dat_o         = rdat;
   assign width_acq_irq_o  = irq[`SMTM_FL_WIDTH];
   assign period_acq_irq_o = irq[`SMTM_FL_PERIOD];
   assign match_irq_o      = irq[`SMTM_FL_MATCH];

   a_wm_period_load: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
      ce_i && en && run && mode == smtm_pkg::SMTM_WMEAS &&
      state == smtm_pkg::SMTM_RUN && win_rise |=> period_latch == $past(count))
      else $error("period latch missed window edge");
   a_tof_sig_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
      ce_i && en && run && legal && mode == smtm_pkg::SMTM_TOF && !wr &&
      state == smtm_pkg::SMTM_RUN && sig_rise |=> count == `SMTM_COUNT_ZERO &&
      state != smtm_pkg::SMTM_RUN)
      else $error("time of flight did not clear on signal");
   a_tof_width_load: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
      ce_i && en && run && mode == smtm_pkg::SMTM_TOF && !sig_rise &&
      state == smtm_pkg::SMTM_RUN && win_rise |=> width_latch == $past(count))
      else $error("width latch missed second window edge");
   a_width_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
      ce_i && set_w |=> flags[`SMTM_FL_WIDTH] ##1 !ce_i || flags[`SMTM_FL_WIDTH] ||
      $past(wr))
      else $error("width flag not raised");
   a_match_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
      ce_i && tick && count == period_limit && ctrl0[`SMTM_C0_HALT] && !wr &&
      req == 3'h0 && !set_p && state == next_state |=> count == $past(period_limit) &&
      flags[`SMTM_FL_MATCH])
      else $error("counter did not hold at limit");
   a_disable_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_13]
      ce_i && !en |=> state == smtm_pkg::SMTM_IDLE && !tick)
      else $error("state machine active while disabled");
   a_req_selfclr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_20]
      ce_i && req[`SMTM_ST_CLR-5] && !wr |=> req == 3'h0 &&
      (count == `SMTM_COUNT_ZERO))
      else $error("manual clear not completed");
   a_single_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_22]
      ce_i && done && !rep && !wr |=> !run ##1 !clock_req_o || ctrl1[`SMTM_C1_RUN])
      else $error("single acquisition did not stop");
   a_capture_noclr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
      ce_i && mode == smtm_pkg::SMTM_CAPT && !wr && req == 3'h0 && !tick
      |=> count == $past(count))
      else $error("capture counter changed by hardware");
endmodule : smtm_top
`default_nettype wire

// ===== tb/smtm_src_model.sv
// window, signal and measurement-clock sources facing the timer
`timescale 1ns/10ps
`default_nettype none
module smtm_src_model (
   output logic win_o,
   output logic sig_o,
   output logic mclk_o,
   input  wire logic clk_i
);
   logic [1:0] div = 2'h0;
   initial
   begin
      win_o = 1'b0;
      sig_o = 1'b0;
   end
   // free-running clock at a quarter rate, slow enough for the sync flops
   always @(posedge clk_i)
   begin
      div    <= div + 2'h1;
      mclk_o <= div[1];
   end
   task automatic window(input logic lvl, input int hold);
      @(posedge clk_i);
      win_o <= lvl;
      repeat (hold) @(posedge clk_i);
   endtask : window
   // pulses wide enough to pass the synchronisers in every mode
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         sig_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         sig_o <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask : pulses
endmodule : smtm_src_model
`default_nettype wire

// ===== tb/tb_smtm_top.sv
// self-checking bench for the measurement timer
`timescale 1ns/10ps
`default_nettype none
`include "smtm_defines.svh"
module tb_smtm_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, win, sig, mclk, w_irq, p_irq, m_irq, creq;
   int          fails = 0, checks_done = 0, cycles = 0;
   always #10 clk_i = ~clk_i;
   smtm_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .window_input_i(win), .signal_input_i(sig), .measure_clock_i(mclk),
      .width_acq_irq_o(w_irq), .period_acq_irq_o(p_irq), .match_irq_o(m_irq),
      .clock_req_o(creq));
   smtm_src_model i_src (.win_o(win), .sig_o(sig), .mclk_o(mclk), .clk_i(clk_i));
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         fails = fails + 1;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // request held until the edge that samples ack, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic prep(input logic [7:0] c0);
      wb(1, `SMTM_OFS_CTRL1, 32'h0);
      wb(1, `SMTM_OFS_COUNT, 32'h0);
      wb(1, `SMTM_OFS_FLAGS, 32'h7);
      wb(1, `SMTM_OFS_CTRL0, {24'h0, c0});
   endtask : prep
   task automatic t_reset_regs;
      wb(0, `SMTM_OFS_CTRL0, 0); chk("ctrl0", 32'h0, q);
      wb(0, `SMTM_OFS_LIMIT, 0); chk("limit", 32'hffffff, q);
      wb(1, 8'h40, 32'hff);
      wb(0, 8'h40, 0); chk("unmapped", 32'h0, q);
   endtask : t_reset_regs
   // counter mode, every prescale code, width latched on window fall
   task automatic t_counter;
      for (int ps = 0; ps < 4; ps++)
      begin
         prep(8'h80 | 8'(ps));
         wb(1, `SMTM_OFS_CTRL1, 32'hc8);
         i_src.window(1'b1, 2);
         i_src.pulses(8);
         i_src.window(1'b0, 6);
         wb(0, `SMTM_OFS_WLATCH, 0); chk("width_latch", 32'd8 >> ps, q);
         wb(0, `SMTM_OFS_FLAGS, 0); chk("flags", 32'h1, q);
         chk("width_irq", 1, {31'h0, w_irq});
         chk("clock_req", 1, {31'h0, creq});
      end
      wb(1, `SMTM_OFS_CTRL0, 32'h0);
      chk("clock_req", 0, {31'h0, creq});
      wb(0, `SMTM_OFS_CTRL1, 0); chk("ctrl1_kept", 32'hc8, q);
   endtask : t_counter
   task automatic t_halt;
      prep(8'ha0);
      wb(1, `SMTM_OFS_LIMIT, 32'h5);
      wb(1, `SMTM_OFS_CTRL1, 32'hc8);
      i_src.pulses(8);
      wb(0, `SMTM_OFS_COUNT, 0); chk("count_held", 32'h5, q);
      wb(0, `SMTM_OFS_FLAGS, 0); chk("match_flag", 32'h4, q & 32'h4);
      chk("match_irq", 1, {31'h0, m_irq});
      wb(1, `SMTM_OFS_LIMIT, 32'hffffff);
   endtask : t_halt
   task automatic t_wmeasure;
      prep(8'h80);
      wb(1, `SMTM_OFS_CTRL1, 32'h84);
      i_src.window(1'b1, 4);
      i_src.window(1'b0, 24);
      i_src.window(1'b1, 4);
      i_src.window(1'b0, 8);
      wb(0, `SMTM_OFS_CTRL1, 0); chk("run_cleared", 32'h04, q);
      wb(0, `SMTM_OFS_FLAGS, 0); chk("period_flag", 32'h2, q);
      chk("period_irq", 1, {31'h0, p_irq});
      // 30 cycles between rises, one measurement clock rise every 4
      wb(0, `SMTM_OFS_PLATCH, 0); chk("period_latch", 1, {31'h0, q >= 7 && q <= 8});
      wb(1, `SMTM_OFS_COUNT, 32'h123);
      wb(1, `SMTM_OFS_STAT, 32'hc0);
      wb(0, `SMTM_OFS_WLATCH, 0); chk("width_req", 32'h123, q);
      wb(1, `SMTM_OFS_STAT, 32'h20);
      wb(0, `SMTM_OFS_STAT, 0); chk("clr_req", 32'h0, q & 32'he0);
      wb(0, `SMTM_OFS_COUNT, 0); chk("count_clr", 32'h0, q);
   endtask : t_wmeasure
   // long low time first so a cleared counter would show up as width below period
   task automatic t_capture;
      logic [31:0] p;
      prep(8'h80);
      wb(1, `SMTM_OFS_CTRL1, 32'hc7);
      i_src.window(1'b0, 40);
      i_src.window(1'b1, 8);
      i_src.window(1'b0, 8);
      wb(0, `SMTM_OFS_FLAGS, 0); chk("capt_flags", 32'h3, q);
      wb(0, `SMTM_OFS_PLATCH, 0); p = q;
      wb(0, `SMTM_OFS_WLATCH, 0); chk("capt_noclr", 1, {31'h0, q > p && p > 8});
   endtask : t_capture
   task automatic t_tof;
      prep(8'h80);
      wb(1, `SMTM_OFS_CTRL1, 32'hc6);
      i_src.window(1'b1, 4);
      i_src.window(1'b0, 4);
      i_src.window(1'b1, 4);
      i_src.pulses(1);
      wb(0, `SMTM_OFS_FLAGS, 0); chk("tof_flags", 32'h3, q);
      wb(0, `SMTM_OFS_COUNT, 0); chk("tof_rearm", 32'h0, q);
   endtask : t_tof
   // pulses before the first window rise must not count
   task automatic t_counted;
      for (int m = 9; m < 11; m++)
      begin
         prep(8'h80);
         i_src.window(1'b0, 4);
         wb(1, `SMTM_OFS_CTRL1, 32'hc0 | m);
         i_src.pulses(2);
         i_src.window(1'b1, 2);
         i_src.pulses(3);
         i_src.window(1'b0, 2);
         i_src.pulses(2);
         i_src.window(1'b1, 2);
         wb(0, `SMTM_OFS_WLATCH, 0); chk("gated_width", 32'h3, q);
         wb(0, `SMTM_OFS_FLAGS, 0); chk("cnt_flags", m == 9 ? 32'h1 : 32'h3, q);
      end
   endtask : t_counted
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_regs();
      wb(1, `SMTM_OFS_IRQEN, 32'h7);
      t_counter();
      t_halt();
      t_wmeasure();
      t_capture();
      t_tof();
      t_counted();
      end_of_test();
   end
endmodule : tb_smtm_top
`default_nettype wire
